// file: design/serial_port.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// RULE1 - full duplex, received characters buffered
// RULE2 - mode 0: data on rxd, clock on txd
// RULE3 - mode 0 shift clock is clock/12
// RULE4 - mode 1: start, 8 data, stop
// RULE5 - mode 1: stop bit becomes received ninth
// RULE6 - mode 2: 11 bits, ninth from software
// RULE7 - modes 2/3: ninth received, stop ignored
// RULE8 - mode 2 rate clock/32 or clock/64
// RULE9 - mode 3 equals mode 2, variable rate
// RULE10 - modes 1/3 pick timer 1 or generator
// RULE11 - generator: free running 10-bit reload counter
// RULE12 - rate 2^double*clock/(64*(1024-reload))
// RULE13 - reload resets to 4.8 kBaud default
// RULE14 - reload split low eight, high two
// RULE15 - counts up, overflow reloads and ticks
module serial_port
   import serial_port_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Timer 1 overflow pulse, same clock
   input wire logic timer1_ovf_i,
   // Serial lines
   input wire logic rxd_i,
   output logic rxd_o,
   output logic rxd_oe_o,
   output logic txd_o
);
   logic wb_ack_ff;
   logic [31:0] wb_dat_ff;
   logic [7:0] ctrl_ff;
   logic [9:0] reload_ff;
   logic pre_ff;
   logic [9:0] gen_ff;
   logic half_ff;
   logic [3:0] m0_cnt_ff;
   tx_state_e tx_state_ff;
   tx_state_e nxt_tx_state;
   logic [10:0] tx_shift_ff;
   logic [3:0] tx_cnt_ff;
   logic [3:0] tx_smp_ff;
   rx_state_e rx_state_ff;
   rx_state_e nxt_rx_state;
   logic [8:0] rx_sh_ff;
   logic [3:0] rx_cnt_ff;
   logic [3:0] rx_smp_ff;
   logic rx_bit_ff;
   logic rxd_s1_ff;
   logic rxd_s2_ff;
   logic rxd_prev_ff;
   logic txd_ff;
   logic rxd_out_ff;
   logic rxd_oe_ff;
   logic nxt_txd;
   logic [31:0] rd_data;

   // Bus decode
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
   wire wr = req & wb_we_i & wb_sel_i[0];
   wire rd = req & ~wb_we_i;
   wire hit_ctrl = (wb_adr_i == CTRL_OFS);
   wire hit_tx = (wb_adr_i == TXDATA_OFS);
   wire hit_rx = (wb_adr_i == RXDATA_OFS);
   wire hit_rl = (wb_adr_i == RELOAD_LOW_OFS);
   wire hit_rh = (wb_adr_i == RELOAD_HIGH_OFS);
   wire wr_ctrl = wr & hit_ctrl;
   wire rx_go = wr_ctrl & wb_dat_i[RX_GO_BIT];

   // Control fields
   mode_e mode;
   assign mode = mode_e'(ctrl_ff[MODE_LSB+1:MODE_LSB]);
   wire rx_en = ctrl_ff[RX_EN_BIT];
   wire tx_ninth = ctrl_ff[TX_NINTH_BIT];
   wire baud_double_bit = ctrl_ff[DOUBLE_BIT];
   wire src_gen = ctrl_ff[SRC_GEN_BIT];
   wire is_shift = (mode == MODE_SHIFT);

   // Receive buffer, drained by reads of the data register
   logic buf_in_ready;
   logic buf_out_valid;
   logic [8:0] buf_out_data;
   wire rx_push_valid = (rx_state_ff == RX_PUSH);
   wire [8:0] rx_push_data = is_shift ? {1'b0, rx_sh_ff[8:1]} : rx_sh_ff;
   wire rx_pop = rd & hit_rx & buf_out_valid;

   two_entry_buffer #(
      .W(9)
   ) rx_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(rx_push_valid),
      .in_ready_o(buf_in_ready),
      .in_data_i(rx_push_data),
      .out_valid_o(buf_out_valid),
      .out_ready_i(rx_pop),
      .out_data_o(buf_out_data)
   );

   wire tx_busy = (tx_state_ff == TX_SHIFT);
   wire tx_start = wr & hit_tx & ~tx_busy;

   // Read mux, unmapped addresses read zero
   // Head word is undefined while the buffer is empty
   wire [31:0] ctrl_rd = {21'h0, tx_busy, buf_out_valid,
                          buf_out_valid & buf_out_data[8], 1'b0, ctrl_ff[6:0]};
   always_comb begin
      if (hit_ctrl) begin
         rd_data = ctrl_rd;
      end else if (hit_rx) begin
         rd_data = {24'h0, buf_out_data[7:0]};
      end else if (hit_rl) begin
         rd_data = {24'h0, reload_ff[7:0]};
      end else if (hit_rh) begin
         rd_data = {30'h0, reload_ff[9:8]};
      end else begin
         rd_data = 32'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_ff <= 1'b0;
         wb_dat_ff <= 32'h0;
      end else begin
         wb_ack_ff <= req;
         wb_dat_ff <= rd ? rd_data : 32'h0;
      end
   end

   // Go bit is a command, never stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_ff <= wb_dat_i[7:0] & ~(8'h1 << RX_GO_BIT);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_ff <= RELOAD_RST; // see RULE13
      end else if (wr & hit_rl) begin
         reload_ff[7:0] <= wb_dat_i[7:0]; // see RULE14
      end else if (wr & hit_rh) begin
         reload_ff[9:8] <= wb_dat_i[1:0]; // see RULE14
      end
   end

   // Baud tick chain: half clock feeds generator and mode 2
   wire osc_half = pre_ff;
   wire gen_ovf = osc_half & (gen_ff == GEN_TOP);
   wire src_tick = (mode == MODE_UART9_FIXED) ? osc_half : // see RULE8
                   src_gen ? gen_ovf : timer1_ovf_i; // see RULE10
   // Undoubled rate drops every other tick
   wire sample_tick = src_tick & (baud_double_bit | half_ff); // see RULE12

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_ff <= 1'b0;
         gen_ff <= RELOAD_RST;
         half_ff <= 1'b0;
      end else begin
         pre_ff <= ~pre_ff;
         half_ff <= half_ff ^ src_tick;
         if (gen_ovf) begin
            gen_ff <= reload_ff; // see RULE15
         end else if (osc_half) begin
            gen_ff <= gen_ff + 10'h1; // see RULE11
         end
      end
   end

   // Mode 0 shift clock: low half then high half of 12 cycles
   wire m0_run = is_shift & (tx_busy | (rx_state_ff == RX_DATA));
   wire m0_end = (m0_cnt_ff == MODE0_DIV - 4'h1);
   wire m0_rise = (m0_cnt_ff == MODE0_HALF);
   always_ff @(posedge clk_i) begin
      if (rst_i | ~m0_run | m0_end) begin
         m0_cnt_ff <= 4'h0; // see RULE3
      end else begin
         m0_cnt_ff <= m0_cnt_ff + 4'h1;
      end
   end

   // Transmitter
   wire [3:0] tx_len = is_shift ? LEN_SHIFT :
                       (mode == MODE_UART8) ? LEN_UART8 : LEN_UART9; // see RULE9
   wire tx_ninth_val = (mode == MODE_UART8) | tx_ninth; // see RULE6
   wire [10:0] tx_frame = is_shift ? {3'h7, wb_dat_i[7:0]} : // see RULE2
                          {1'b1, tx_ninth_val, wb_dat_i[7:0], 1'b0}; // see RULE4
   wire tx_bit_end = is_shift ? m0_end :
                     (sample_tick & (tx_smp_ff == SMP_LAST));
   wire tx_last = (tx_cnt_ff == tx_len - 4'h1);

   always_comb begin
      nxt_tx_state = tx_state_ff;
      case (tx_state_ff)
         TX_IDLE: begin
            if (tx_start) begin
               nxt_tx_state = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (tx_bit_end & tx_last) begin
               nxt_tx_state = TX_IDLE;
            end
         end
         default: begin
            nxt_tx_state = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_state_ff <= TX_IDLE;
         tx_shift_ff <= 11'h7FF;
         tx_cnt_ff <= 4'h0;
         tx_smp_ff <= 4'h0;
      end else begin
         tx_state_ff <= nxt_tx_state;
         if (tx_start) begin
            tx_shift_ff <= tx_frame;
            tx_cnt_ff <= 4'h0;
            tx_smp_ff <= 4'h0;
         end else if (tx_busy) begin
            if (~is_shift & sample_tick) begin
               tx_smp_ff <= tx_smp_ff + 4'h1;
            end
            if (tx_bit_end) begin
               tx_shift_ff <= {1'b1, tx_shift_ff[10:1]}; // see RULE4
               tx_cnt_ff <= tx_cnt_ff + 4'h1;
            end
         end
      end
   end

   // Receiver; pins pass two flops first
   wire rxd = rxd_s2_ff;
   // Edge, not level: a low stop bit must not open a frame
   wire rx_fall = rxd_prev_ff & ~rxd;
   wire [3:0] rx_len = is_shift ? LEN_SHIFT :
                       (mode == MODE_UART8) ? LEN_UART8 - 4'h1 : LEN_UART9 - 4'h1;
   wire rx_sample = is_shift ? m0_rise :
                    (sample_tick & (rx_smp_ff == SMP_LAST));
   wire rx_bit_end = is_shift ? m0_end : rx_sample;
   wire rx_last = (rx_cnt_ff == rx_len - 4'h1);
   wire start_seen = sample_tick & (rx_smp_ff == START_CHECK);

   always_comb begin
      nxt_rx_state = rx_state_ff;
      case (rx_state_ff)
         RX_IDLE: begin
            if (rx_en & is_shift & rx_go & ~tx_busy) begin
               nxt_rx_state = RX_DATA;
            end else if (rx_en & ~is_shift & rx_fall) begin
               nxt_rx_state = RX_START;
            end
         end
         RX_START: begin
            if (start_seen) begin
               nxt_rx_state = rxd ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (rx_bit_end & rx_last) begin
               nxt_rx_state = RX_PUSH;
            end
         end
         RX_PUSH: begin
            // Stall here while the buffer is full
            if (buf_in_ready) begin
               nxt_rx_state = RX_IDLE; // see RULE1
            end
         end
         default: begin
            nxt_rx_state = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxd_s1_ff <= 1'b1;
         rxd_s2_ff <= 1'b1;
         rxd_prev_ff <= 1'b1;
         rx_state_ff <= RX_IDLE;
         rx_sh_ff <= 9'h0;
         rx_cnt_ff <= 4'h0;
         rx_smp_ff <= 4'h0;
         rx_bit_ff <= 1'b1;
      end else begin
         rxd_s1_ff <= rxd_i;
         rxd_s2_ff <= rxd_s1_ff;
         rxd_prev_ff <= rxd_s2_ff;
         rx_state_ff <= nxt_rx_state;
         if (rx_state_ff == RX_IDLE) begin
            rx_cnt_ff <= 4'h0;
            rx_smp_ff <= 4'h0;
         end else if (start_seen & (rx_state_ff == RX_START)) begin
            rx_smp_ff <= 4'h0;
         end else if (sample_tick) begin
            rx_smp_ff <= rx_smp_ff + 4'h1;
         end
         if ((rx_state_ff == RX_DATA) & rx_sample) begin
            rx_bit_ff <= rxd;
            // Bits past the ninth (mode 2/3 stop) are dropped
            if (rx_cnt_ff < RX_KEEP) begin
               rx_sh_ff <= {rxd, rx_sh_ff[8:1]}; // see RULE5 RULE7
            end
         end
         if ((rx_state_ff == RX_DATA) & rx_bit_end) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
         end
      end
   end

   // Pin drive: mode 0 owns rxd while sending
   always_comb begin
      if (is_shift & m0_run) begin
         nxt_txd = (m0_cnt_ff >= MODE0_HALF); // see RULE2
      end else if (tx_busy) begin
         nxt_txd = tx_shift_ff[0];
      end else begin
         nxt_txd = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txd_ff <= 1'b1;
         rxd_out_ff <= 1'b1;
         rxd_oe_ff <= 1'b0;
      end else begin
         txd_ff <= nxt_txd;
         rxd_out_ff <= (is_shift & tx_busy) ? tx_shift_ff[0] : 1'b1;
         rxd_oe_ff <= is_shift & tx_busy; // see RULE2
      end
   end

   assign wb_ack_o = wb_ack_ff;
   assign wb_dat_o = wb_dat_ff;
   assign txd_o = txd_ff;
   assign rxd_o = rxd_out_ff;
   assign rxd_oe_o = rxd_oe_ff;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence async_start_s;
      tx_start & ~is_shift;
   endsequence
   sequence start_low_s;
      ##2 ~txd_o;
   endsequence

   reload_default_a: assert property ( // see RULE13
      disable iff (1'b0) rst_i |=> (reload_ff == RELOAD_RST))
      else $error("reload not at default after reset");
   gen_reload_a: assert property ( // see RULE15
      gen_ovf |=> (gen_ff == $past(reload_ff)))
      else $error("generator did not reload on overflow");
   gen_count_a: assert property ( // see RULE11
      osc_half & ~gen_ovf |=> (gen_ff == $past(gen_ff) + 10'h1))
      else $error("generator did not count up");
   shift_clock_a: assert property ( // see RULE3
      $rose(txd_o) & is_shift & tx_busy |-> txd_o [*6])
      else $error("mode 0 clock high phase not six cycles");
   start_bit_a: assert property ( // see RULE4
      async_start_s |-> start_low_s)
      else $error("async frame did not begin with a low start bit");
   tx_ninth_a: assert property ( // see RULE6
      tx_start & mode[1] |=> (tx_shift_ff[9] == $past(tx_ninth)))
      else $error("transmitted ninth bit not from control");
   rx_stop_ninth_a: assert property ( // see RULE5
      rx_push_valid & (mode == MODE_UART8) |-> (rx_push_data[8] == rx_bit_ff))
      else $error("mode 1 stop bit not stored as ninth");
   mode2_rate_a: assert property ( // see RULE8
      (mode == MODE_UART9_FIXED) & baud_double_bit & sample_tick
      |=> ~sample_tick ##1 sample_tick)
      else $error("mode 2 doubled sample rate not clock/2");
   push_hold_a: assert property ( // see RULE1
      rx_push_valid & ~buf_in_ready |=> rx_push_valid & $stable(rx_push_data))
      else $error("received word lost under stall");
endmodule : serial_port
`default_nettype wire

// file: design/serial_port_pkg.sv
package serial_port_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] TXDATA_OFS = 8'h04;
   localparam logic [7:0] RXDATA_OFS = 8'h08;
   localparam logic [7:0] RELOAD_LOW_OFS = 8'h0C;
   localparam logic [7:0] RELOAD_HIGH_OFS = 8'h10;
   // Control register fields
   localparam int MODE_LSB = 0;
   localparam int RX_EN_BIT = 2;
   localparam int TX_NINTH_BIT = 3;
   localparam int DOUBLE_BIT = 4;
   localparam int SRC_GEN_BIT = 5;
   localparam int RX_GO_BIT = 6;
   localparam int RX_NINTH_BIT = 8;
   localparam int RX_VALID_BIT = 9;
   localparam int TX_BUSY_BIT = 10;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   // 1024 - 39: nearest 4.8 kBaud at 12 MHz, 9.6 kBaud when doubled
   localparam logic [9:0] RELOAD_RST = 10'h3D9;
   localparam logic [9:0] GEN_TOP = 10'h3FF;
   // Timing counts in clock cycles or sample ticks
   localparam logic [3:0] MODE0_DIV = 4'hC;
   localparam logic [3:0] MODE0_HALF = 4'h6;
   localparam logic [3:0] SMP_LAST = 4'hF;
   localparam logic [3:0] START_CHECK = 4'h7;
   // Frame lengths in bits
   localparam logic [3:0] LEN_SHIFT = 4'h8;
   localparam logic [3:0] LEN_UART8 = 4'hA;
   localparam logic [3:0] LEN_UART9 = 4'hB;
   localparam logic [3:0] RX_KEEP = 4'h9;

   typedef enum logic [1:0] {
      MODE_SHIFT = 2'h0,
      MODE_UART8 = 2'h1,
      MODE_UART9_FIXED = 2'h2,
      MODE_UART9_VAR = 2'h3
   } mode_e;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SHIFT = 2'b10
   } tx_state_e;

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_PUSH = 4'b1000
   } rx_state_e;
endpackage : serial_port_pkg

// file: design/two_entry_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
   parameter int W = 9
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // Draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   logic [W-1:0] mem_ff [0:1];
   logic wr_ptr_ff;
   logic rd_ptr_ff;
   logic [1:0] count_ff;
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;

   assign in_ready_o = (count_ff != 2'h2);
   assign out_valid_o = (count_ff != 2'h0);
   assign out_data_o = mem_ff[rd_ptr_ff];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         count_ff <= 2'h0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff ^ push;
         rd_ptr_ff <= rd_ptr_ff ^ pop;
         count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : two_entry_buffer
`default_nettype wire

// file: dv/serial_partner.sv
`timescale 1ns/10ps
`default_nettype none
module serial_partner (
   // Clock
   input wire logic clk_i,
   // Far side of the serial lines
   input wire logic sclk_i,
   output logic line_o
);
   // Released line reads high, as with a pull-up
   initial line_o = 1'b1;

   task automatic send(input logic [10:0] f, input int n, input int b);
      for (int i = 0; i < n; i++) begin
         line_o <= f[i];
         repeat (b) @(posedge clk_i);
      end
      // One idle bit so a zero stop bit still leaves a falling edge for the next start
      line_o <= 1'b1;
      repeat (b) @(posedge clk_i);
   endtask : send

   task automatic shift_reply(input logic [7:0] v);
      int k;
      for (int i = 0; i < 8; i++) begin
         k = 0;
         do @(posedge clk_i); while (sclk_i !== 1'b0 && k++ < 100);
         line_o <= v[i];
         k = 0;
         do @(posedge clk_i); while (sclk_i !== 1'b1 && k++ < 100);
      end
      line_o <= 1'b1;
   endtask : shift_reply
endmodule : serial_partner
`default_nettype wire

// file: dv/serial_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module serial_port_tb
   import serial_port_pkg::*;
;
   logic clk_i, rst_i, cyc, stb, we, ack, t1, rxd_o, rxd_oe, txd, txd_q;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, q;
   wire far_line;
   wire rxd_line;
   int failures = 0;
   int n_checks = 0;

   // Pin level: device drives only in mode 0 transmit
   assign rxd_line = rxd_oe ? rxd_o : far_line;

   serial_port serial_port_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .timer1_ovf_i(t1),
      .rxd_i(rxd_line), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe), .txd_o(txd));
   serial_partner serial_partner_inst (.clk_i(clk_i), .sclk_i(txd), .line_o(far_line));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Timer 1 overflow every second clock
   always @(posedge clk_i) t1 <= ~t1;
   always @(posedge clk_i) txd_q <= txd;

   task test_done();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1 && n++ < 50);
      if (ack !== 1'b1) failures++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rdc

   task poll(input int p, input logic v);
      int k;
      k = 0;
      do bus(1'b0, CTRL_OFS, 32'h0); while (q[p] !== v && k++ < 300);
   endtask : poll

   task rx_pop(input logic [7:0] v, input logic n9, input logic use9);
      poll(RX_VALID_BIT, 1'b1);
      if (use9) chk(32'(q[RX_NINTH_BIT]), 32'(n9));
      bus(1'b0, RXDATA_OFS, 32'h0);
      chk(q & 32'hFF, 32'(v));
   endtask : rx_pop

   task tx_frame(input logic [10:0] f, input int n, input int b);
      int k;
      k = 0;
      do @(posedge clk_i); while (txd !== 1'b0 && k++ < 2000);
      repeat (b / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         chk(32'(txd), 32'(f[i]));
         repeat (b) @(posedge clk_i);
      end
   endtask : tx_frame

   task m0_tx(input logic [7:0] v);
      int k, last;
      k = 0;
      last = 0;
      for (int i = 0; i < 8; i++) begin
         do begin
            @(posedge clk_i);
            k++;
         end while (!(txd === 1'b1 && txd_q === 1'b0) && k < 1000);
         chk(32'({rxd_oe, rxd_o}), 32'({1'b1, v[i]}));
         if (i > 0) chk(k - last, 12);
         last = k;
      end
   endtask : m0_tx

   // Transmit and three receptions overlap; the third waits on a full buffer until a read
   task uart(input logic [7:0] ctl, input int b, input logic [10:0] tf, input logic [10:0] rf, input int n,
         input logic n9);
      poll(TX_BUSY_BIT, 1'b0);
      bus(1'b1, CTRL_OFS, 32'(ctl));
      fork
         begin
            bus(1'b1, TXDATA_OFS, 32'(tf[8:1]));
            tx_frame(tf, n, b);
         end
         begin
            serial_partner_inst.send(rf, n, b);
            serial_partner_inst.send(rf ^ 11'h1FE, n, b);
            serial_partner_inst.send(rf, n, b);
         end
      join
      rx_pop(rf[8:1], n9, 1'b1);
      rx_pop(~rf[8:1], n9, 1'b1);
      rx_pop(rf[8:1], n9, 1'b1);
   endtask : uart

   initial begin
      repeat (60000) @(posedge clk_i);
      failures++;
      test_done();
   end

   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      t1 = 1'b0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(CTRL_OFS, 32'h0);
      rdc(RELOAD_LOW_OFS, 32'hD9);
      rdc(RELOAD_HIGH_OFS, 32'h3);
      bus(1'b1, 8'h14, 32'hFF);
      rdc(8'h14, 32'h0);
      bus(1'b1, CTRL_OFS, 32'h0);
      bus(1'b1, TXDATA_OFS, 32'h96);
      m0_tx(8'h96);
      poll(TX_BUSY_BIT, 1'b0);
      // Receiver enable must already stand when the go strobe arrives
      bus(1'b1, CTRL_OFS, 32'h4);
      fork
         serial_partner_inst.shift_reply(8'h5A);
         bus(1'b1, CTRL_OFS, 32'h44);
      join
      rx_pop(8'h5A, 1'b0, 1'b0);
      bus(1'b1, RELOAD_LOW_OFS, 32'hFE);
      bus(1'b1, RELOAD_HIGH_OFS, 32'h3);
      rdc(RELOAD_LOW_OFS, 32'hFE);
      uart(8'h35, 64, {2'b11, 8'hA5, 1'b0}, {2'b11, 8'h3C, 1'b0}, 10, 1'b1);
      uart(8'h25, 128, {2'b11, 8'h69, 1'b0}, {2'b11, 8'h0F, 1'b0}, 10, 1'b1);
      uart(8'h05, 64, {2'b11, 8'hC3, 1'b0}, {2'b11, 8'h96, 1'b0}, 10, 1'b1);
      for (int d = 0; d < 2; d++)
         uart(8'h06 | 8'(d * 24), 64 >> d, {1'b1, d[0], 8'h55, 1'b0}, {1'b0, ~d[0], 8'h81, 1'b0}, 11, ~d[0]);
      uart(8'h1F, 32, {2'b11, 8'h3C, 1'b0}, {2'b11, 8'hE7, 1'b0}, 11, 1'b1);
      test_done();
   end
endmodule : serial_port_tb
`default_nettype wire
